// >>> src/flash_cmd_consts.svh
/*
  Opcodes, status bit positions and timing counts for the flash
  instruction core. Assumes a 250 MHz system clock.
*/
`ifndef FLASH_CMD_CONSTS_SVH
`define FLASH_CMD_CONSTS_SVH
`define OP_WHOLE_ERASE_A   8'hC7
`define OP_WHOLE_ERASE_B   8'h60
`define OP_SUSPEND         8'h75
`define OP_RESUME          8'h7A
`define OP_POWER_DOWN      8'hB9
`define OP_RELEASE_ID      8'hAB
`define OP_READ_IDS        8'h90
`define OP_READ_STATUS     8'h05
`define OP_BITS            6'h08
`define ID_START_BITS      6'h20
`define BITS_SATURATE      6'h28
`define STATUS_BUSY_BIT    0
`define STATUS_WEL_BIT     1
`define PROTECT_ALL_BLOCKS 3'h7
`define CLK_PERIOD_NS      4
`define POWER_DOWN_ENTRY_NS 3000
`define FIRST_RELEASE_NS   3000
`define SECOND_RELEASE_NS  1800
`define RESUME_BUSY_NS     200
`define WHOLE_ERASE_NS     1000000
`define POWER_DOWN_ENTRY_CYC (`POWER_DOWN_ENTRY_NS / `CLK_PERIOD_NS)
`define FIRST_RELEASE_CYC  (`FIRST_RELEASE_NS / `CLK_PERIOD_NS)
`define SECOND_RELEASE_CYC (`SECOND_RELEASE_NS / `CLK_PERIOD_NS)
`define RESUME_BUSY_CYC    (`RESUME_BUSY_NS / `CLK_PERIOD_NS)
`define WHOLE_ERASE_CYC    (`WHOLE_ERASE_NS / `CLK_PERIOD_NS)
`endif

// >>> src/flash_cmd_pkg.sv
/*
  Types shared by the flash instruction core.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package flash_cmd_pkg;
  typedef enum logic [1:0] {
    PWR_NORMAL,
    PWR_ENTERING,
    PWR_DOWN,
    PWR_RELEASING
  } power_state_e;

  typedef enum logic [1:0] {
    KIND_NONE,
    KIND_ERASE,
    KIND_PROGRAM,
    KIND_WHOLE
  } run_kind_e;
endpackage
`default_nettype wire

// >>> src/link_if.sv
/*
  Filtered serial link levels passed from the pin filter to the core.
  Assumes both ends run on the system clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface link_if;
  logic sck;
  logic cs_n;
  logic mosi;
  modport filter (output sck, output cs_n, output mosi);
  modport core   (input sck, input cs_n, input mosi);
endinterface
`default_nettype wire

// >>> src/pin_filter.sv
/*
  Three-stage pin synchroniser; a level is taken once the second and
  third stages agree. Assumes asynchronous pins and a synchronous reset.
*/
`timescale 1ns/100ps
`default_nettype none
module pin_filter #(
  parameter int unsigned WIDTH     = 3,
  parameter logic [2:0]  RESET_VAL = 3'h2
) (
  input  wire logic             clk_sys_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] pins_i,
  link_if.filter                link
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] stable_q;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      s1_q     <= RESET_VAL;
      s2_q     <= RESET_VAL;
      s3_q     <= RESET_VAL;
      stable_q <= RESET_VAL;
    end else begin
      s1_q <= pins_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          stable_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign {link.sck, link.cs_n, link.mosi} = stable_q;
endmodule
`default_nettype wire

// >>> src/flash_cmd_core.sv
/*
  Instruction core of a serial flash: whole erase, suspend and resume,
  deep power-down and release, identification reads and status read.
  Assumes the array logic starts and ends sector, block and page work
  through op_start_i and op_done_i, and honours op_hold_o.
*/
`timescale 1ns/100ps
`default_nettype none
`include "flash_cmd_consts.svh"
module flash_cmd_core #(
  parameter int unsigned WHOLE_ERASE_CYC = `WHOLE_ERASE_CYC,
  parameter logic [7:0]  MFG_ID          = 8'h5A,
  parameter logic [7:0]  DEVICE_ID       = 8'h3C
) (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  input  wire logic       spi_cs_n_i,
  input  wire logic       spi_sck_i,
  input  wire logic       spi_mosi_i,
  output var  logic       spi_miso_o,
  output var  logic       spi_miso_oe_o,
  input  wire logic       write_enable_set_i,
  input  wire logic       op_start_i,
  input  wire logic       op_is_program_i,
  input  wire logic       op_done_i,
  input  wire logic       protect_complement_i,
  input  wire logic [2:0] block_protect_i,
  output var  logic       write_enable_latch_o,
  output var  logic       busy_o,
  output var  logic       suspend_status_flag_o,
  output var  logic       power_down_o,
  output var  logic       op_hold_o,
  output var  logic       array_fill_o,
  output var  logic       erase_allowed_o,
  output var  logic       program_allowed_o,
  output var  logic       status_write_allowed_o
);
  import flash_cmd_pkg::*;

  // MFG_ID and DEVICE_ID defaults are arbitrary values.
  localparam int PD_MAX     = `POWER_DOWN_ENTRY_CYC + 1;
  localparam int RESUME_MAX = `RESUME_BUSY_CYC;

  // ----------------------------------------
  // Pin filtering and edges
  // ----------------------------------------
  link_if link ();

  pin_filter #(
    .WIDTH     (3),
    .RESET_VAL (3'h2)
  ) pin_filter_i (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .pins_i    ({spi_sck_i, spi_cs_n_i, spi_mosi_i}),
    .link      (link.filter)
  );

  logic sck_prev_q, cs_prev_q;
  logic in_frame, sck_rise, sck_fall, frame_end;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      sck_prev_q <= 1'b0;
      cs_prev_q  <= 1'b1;
    end else begin
      sck_prev_q <= link.sck;
      cs_prev_q  <= link.cs_n;
    end
  end

  assign in_frame  = ~link.cs_n;
  assign sck_rise  = in_frame & link.sck & ~sck_prev_q;
  assign sck_fall  = in_frame & ~link.sck & sck_prev_q;
  assign frame_end = link.cs_n & ~cs_prev_q;

  // ----------------------------------------
  // Opcode and address shifting
  // ----------------------------------------
  logic [5:0]  bits_q;
  logic [7:0]  shift_q;
  logic [7:0]  opcode_q;
  logic [23:0] addr_q;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      bits_q   <= 6'h00;
      shift_q  <= 8'h00;
      opcode_q <= 8'h00;
      addr_q   <= 24'h000000;
    end else if (!in_frame) begin
      bits_q <= 6'h00;
    end else if (sck_rise) begin
      if (bits_q != `BITS_SATURATE) begin
        bits_q <= bits_q + 6'h01;
      end
      shift_q <= {shift_q[6:0], link.mosi};
      if (bits_q == `OP_BITS - 6'h01) begin
        opcode_q <= {shift_q[6:0], link.mosi};
      end
      if (bits_q >= `OP_BITS && bits_q < `ID_START_BITS) begin
        addr_q <= {addr_q[22:0], link.mosi};
      end
    end
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  power_state_e pwr_q;
  run_kind_e    run_q;
  run_kind_e    held_q;
  logic         busy_q, sus_q, wel_q;
  logic [31:0]  whole_cnt_q;
  logic [31:0]  pwr_cnt_q;

  logic is_whole, is_susp, is_res, is_pd, is_rel, is_ids, is_stat;
  logic one_byte, pwr_normal, prot_any;
  logic whole_go, susp_go, res_go, pd_go, rel_go;
  logic whole_done, ext_done, start_ok;

  assign is_whole = (opcode_q == `OP_WHOLE_ERASE_A) |
                    (opcode_q == `OP_WHOLE_ERASE_B);
  assign is_susp  = opcode_q == `OP_SUSPEND;
  assign is_res   = opcode_q == `OP_RESUME;
  assign is_pd    = opcode_q == `OP_POWER_DOWN;
  assign is_rel   = opcode_q == `OP_RELEASE_ID;
  assign is_ids   = opcode_q == `OP_READ_IDS;
  assign is_stat  = opcode_q == `OP_READ_STATUS;

  assign pwr_normal = pwr_q == PWR_NORMAL;
  assign one_byte   = frame_end & (bits_q == `OP_BITS) & pwr_normal;
  assign prot_any   = protect_complement_i ? (block_protect_i != `PROTECT_ALL_BLOCKS) :
                      (block_protect_i != 3'h0);

  // Whole erase also refused during either kind of suspend
  assign whole_go = one_byte & is_whole & wel_q & ~busy_q
                    & ~sus_q & ~prot_any;
  assign susp_go  = one_byte & is_susp & ~sus_q & busy_q &
                    ((run_q == KIND_ERASE) | (run_q == KIND_PROGRAM));
  assign res_go   = one_byte & is_res & sus_q & ~busy_q;
  assign pd_go    = one_byte & is_pd;
  assign rel_go   = frame_end & (pwr_q == PWR_DOWN) & is_rel & ~busy_q &
                    ((bits_q == `OP_BITS) |
                     (bits_q >= `ID_START_BITS));

  assign whole_done = (run_q == KIND_WHOLE) & (whole_cnt_q == 32'h0);
  assign ext_done   = op_done_i & busy_q &
                      ((run_q == KIND_ERASE) | (run_q == KIND_PROGRAM));
  assign start_ok   = op_start_i & ~busy_q & wel_q & pwr_normal &
                      ~(sus_q & (held_q == KIND_ERASE) & ~op_is_program_i) &
                      ~(sus_q & (held_q == KIND_PROGRAM) & op_is_program_i);

  // ----------------------------------------
  // Busy, suspend and work tracking
  // ----------------------------------------
  logic fill_q, pd_q;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      busy_q      <= 1'b0;
      sus_q       <= 1'b0;
      run_q       <= KIND_NONE;
      held_q      <= KIND_NONE;
      whole_cnt_q <= 32'h0;
      fill_q      <= 1'b0;
    end else begin
      fill_q <= 1'b0;
      if (whole_go) begin
        busy_q      <= 1'b1;
        run_q       <= KIND_WHOLE;
        whole_cnt_q <= WHOLE_ERASE_CYC - 1;
      end else if (whole_done) begin
        busy_q <= 1'b0;
        run_q  <= KIND_NONE;
        fill_q <= 1'b1;
      end else if (run_q == KIND_WHOLE) begin
        whole_cnt_q <= whole_cnt_q - 32'h1;
      end else if (susp_go) begin
        sus_q  <= 1'b1;
        busy_q <= 1'b0;
        held_q <= run_q;
        run_q  <= KIND_NONE;
      end else if (res_go) begin
        sus_q  <= 1'b0;
        busy_q <= 1'b1;
        run_q  <= held_q;
        held_q <= KIND_NONE;
      end else if (start_ok) begin
        busy_q <= 1'b1;
        run_q  <= op_is_program_i ? KIND_PROGRAM : KIND_ERASE;
      end else if (ext_done) begin
        busy_q <= 1'b0;
        run_q  <= KIND_NONE;
      end
    end
  end

  // ----------------------------------------
  // Write enable latch
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      wel_q <= 1'b0;
    end else if (write_enable_set_i) begin
      wel_q <= 1'b1;
    end else if (whole_done | ext_done) begin
      wel_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Power state
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pwr_q     <= PWR_NORMAL;
      pd_q      <= 1'b0;
      pwr_cnt_q <= 32'h0;
    end else begin
      unique case (pwr_q)
        PWR_NORMAL: begin
          if (pd_go) begin
            pwr_q     <= PWR_ENTERING;
            pwr_cnt_q <= `POWER_DOWN_ENTRY_CYC - 1;
          end
        end
        PWR_ENTERING: begin
          if (pwr_cnt_q == 32'h0) begin
            pwr_q <= PWR_DOWN;
            pd_q  <= 1'b1;
          end else begin
            pwr_cnt_q <= pwr_cnt_q - 32'h1;
          end
        end
        PWR_DOWN: begin
          if (rel_go) begin
            pwr_q     <= PWR_RELEASING;
            pd_q      <= 1'b0;
            pwr_cnt_q <= (bits_q == `OP_BITS) ?
                         `FIRST_RELEASE_CYC - 1 :
                         `SECOND_RELEASE_CYC - 1;
          end
        end
        PWR_RELEASING: begin
          if (pwr_cnt_q == 32'h0) begin
            pwr_q <= PWR_NORMAL;
          end else begin
            pwr_cnt_q <= pwr_cnt_q - 32'h1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Serial output
  // ----------------------------------------
  logic [2:0] tx_bit_q;
  logic       tx_sel_q, miso_q, oe_q;
  logic       tx_stat, tx_dev, tx_ids, tx_on;
  logic [7:0] tx_byte;

  assign tx_stat = pwr_normal & is_stat & (bits_q >= `OP_BITS);
  assign tx_dev  = is_rel & ~busy_q & (bits_q >= `ID_START_BITS) &
                   (pwr_normal | (pwr_q == PWR_DOWN));
  assign tx_ids  = pwr_normal & is_ids & (bits_q >= `ID_START_BITS) &
                   (addr_q[23:1] == 23'h0);
  assign tx_on   = tx_stat | tx_dev | tx_ids;

  always_comb begin
    tx_byte = 8'h00;
    if (tx_stat) begin
      tx_byte[`STATUS_BUSY_BIT] = busy_q;
      tx_byte[`STATUS_WEL_BIT]  = wel_q;
    end else if (tx_dev) begin
      tx_byte = DEVICE_ID;
    end else if (tx_sel_q ^ addr_q[0]) begin
      tx_byte = DEVICE_ID;
    end else begin
      tx_byte = MFG_ID;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i || !in_frame) begin
      tx_bit_q <= 3'h0;
      tx_sel_q <= 1'b0;
      miso_q   <= 1'b0;
      oe_q     <= 1'b0;
    end else if (sck_fall && tx_on) begin
      oe_q     <= 1'b1;
      miso_q   <= tx_byte[3'h7 - tx_bit_q];
      tx_bit_q <= tx_bit_q + 3'h1;
      if (tx_bit_q == 3'h7) begin
        tx_sel_q <= ~tx_sel_q;
      end
    end
  end

  // ----------------------------------------
  // Permission outputs
  // ----------------------------------------
  logic erase_ok_q, prog_ok_q, swr_ok_q;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      erase_ok_q <= 1'b1;
      prog_ok_q  <= 1'b1;
      swr_ok_q   <= 1'b1;
    end else begin
      erase_ok_q <= ~sus_q;
      prog_ok_q  <= ~(sus_q & (held_q == KIND_PROGRAM));
      swr_ok_q   <= ~sus_q;
    end
  end

  assign spi_miso_o             = miso_q;
  assign spi_miso_oe_o          = oe_q;
  assign write_enable_latch_o   = wel_q;
  assign busy_o                 = busy_q;
  assign suspend_status_flag_o  = sus_q;
  assign power_down_o           = pd_q;
  assign op_hold_o              = sus_q;
  assign array_fill_o           = fill_q;
  assign erase_allowed_o        = erase_ok_q;
  assign program_allowed_o      = prog_ok_q;
  assign status_write_allowed_o = swr_ok_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  whole_wel_a: assert property (one_byte & is_whole & ~wel_q |=> run_q != KIND_WHOLE)
    else $error("whole erase started without write enable");
  whole_cut_a: assert property (frame_end & is_whole & (bits_q != `OP_BITS) & ~busy_q
    |=> run_q != KIND_WHOLE)
    else $error("whole erase started on a cut frame");
  whole_end_a: assert property (whole_done & ~write_enable_set_i |=> ~busy_q & ~wel_q & fill_q)
    else $error("whole erase end left busy or latch set");
  whole_prot_a: assert property (one_byte & is_whole & prot_any & ~busy_q |=> run_q != KIND_WHOLE)
    else $error("whole erase ran on protected array");
  susp_take_a: assert property (susp_go |=> sus_q & ~busy_q & (held_q != KIND_NONE))
    else $error("suspend not taken");
  susp_whole_a: assert property (one_byte & is_susp & (run_q == KIND_WHOLE)
    |=> ~sus_q ##1 busy_q | whole_done)
    else $error("suspend hit a whole erase");
  susp_refuse_a: assert property (sus_q & (held_q == KIND_ERASE) & op_start_i & ~op_is_program_i
    |=> run_q != KIND_ERASE)
    else $error("erase started during erase suspend");
  resume_a: assert property (res_go |=> ~sus_q ##[0:RESUME_MAX] busy_q)
    else $error("resume did not restart work");
  resume_skip_a: assert property (one_byte & is_res & (~sus_q | busy_q) |=> $stable(sus_q))
    else $error("resume accepted in wrong state");
  pd_enter_a: assert property (pd_go |-> ##[1:PD_MAX] pwr_q == PWR_DOWN)
    else $error("power-down not reached in time");
  pd_quiet_a: assert property ((pwr_q == PWR_DOWN) & ~is_rel |=> ~oe_q)
    else $error("output driven in power-down");
  power_up_a: assert property ($fell(reset_i) |-> pwr_q == PWR_NORMAL)
    else $error("not normal after reset");
  release_busy_a: assert property (frame_end & is_rel & busy_q |=> pwr_q == $past(pwr_q))
    else $error("release acted while busy");
endmodule
`default_nettype wire

// >>> verif/spi_host_model.sv
/*
  Host SPI controller model, mode 0, for the flash instruction core.
  Assumes the system clock; each sck half period lasts 8 clock cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  input  wire logic clk_sys_i,
  input  wire logic spi_miso_i,
  input  wire logic spi_miso_oe_i,
  output var  logic spi_cs_n_o,
  output var  logic spi_sck_o,
  output var  logic spi_mosi_o
);
  initial begin
    spi_cs_n_o = 1'b1;
    spi_sck_o  = 1'b0;
    spi_mosi_o = 1'b0;
  end

  task automatic half();
    repeat (8) @(posedge clk_sys_i);
  endtask

  // -------------------------------------------------------
  // One frame: n_in bits out MSB first, then n_rd bits in
  // -------------------------------------------------------
  task automatic frame(input logic [39:0] din, input int n_in, input int n_rd,
                       output logic [15:0] rd, output logic oe);
    rd = 16'h0000;
    oe = 1'b0;
    spi_cs_n_o <= 1'b0;
    for (int i = 0; i < n_in; i++) begin
      spi_mosi_o <= din[39-i];
      half();
      spi_sck_o <= 1'b1;
      half();
      spi_sck_o <= 1'b0;
    end
    for (int i = 0; i < n_rd; i++) begin
      spi_mosi_o <= ~spi_mosi_o;
      half();
      rd = {rd[14:0], spi_miso_i};
      oe = oe | spi_miso_oe_i;
      spi_sck_o <= 1'b1;
      half();
      spi_sck_o <= 1'b0;
    end
    half();
    spi_cs_n_o <= 1'b1;
    spi_mosi_o <= ~spi_mosi_o;
    half();
    half();
  endtask
endmodule
`default_nettype wire

// >>> verif/flash_erase_suspend_powerdown_id_tb.sv
/*
  Self-checking bench for the flash instruction core.
  Assumes the host model drives the pins and the core is the top.
*/
`timescale 1ns/100ps
`default_nettype none
`include "flash_cmd_consts.svh"
module flash_erase_suspend_powerdown_id_tb;
  localparam int         W   = 2000;
  localparam logic [7:0] MFG = 8'h96;  // Arbitrary value
  localparam logic [7:0] DEV = 8'h17;  // Arbitrary value
  typedef struct {logic [39:0] din; int n_in; logic [15:0] exp;} row_s;

  logic        clk_sys_i = 1'b0;
  logic        reset_i   = 1'b1;
  logic        cs_n, sck, mosi, miso, miso_oe;
  logic        we_set    = 1'b0;
  logic        op_start  = 1'b0;
  logic        op_prog   = 1'b0;
  logic        op_done   = 1'b0;
  logic        cmp       = 1'b0;
  logic [2:0]  bp        = 3'h0;
  logic        write_enable_latch, busy, suspend_status_flag, pd, hold, fill, e_ok, p_ok, sw_ok;
  logic [15:0] rd;
  logic        oe;
  row_s        rows [4];
  int          mismatches      = 0;
  int          samples_checked = 0;

  always #2 clk_sys_i = ~clk_sys_i;

  flash_cmd_core #(.WHOLE_ERASE_CYC(W), .MFG_ID(MFG), .DEVICE_ID(DEV)) flash_cmd_core_i (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .spi_cs_n_i(cs_n), .spi_sck_i(sck),
    .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe),
    .write_enable_set_i(we_set), .op_start_i(op_start), .op_is_program_i(op_prog),
    .op_done_i(op_done), .protect_complement_i(cmp), .block_protect_i(bp),
    .write_enable_latch_o(write_enable_latch), .busy_o(busy), .suspend_status_flag_o(suspend_status_flag),
    .power_down_o(pd), .op_hold_o(hold), .array_fill_o(fill), .erase_allowed_o(e_ok),
    .program_allowed_o(p_ok), .status_write_allowed_o(sw_ok));

  spi_host_model spi_host_model_i (
    .clk_sys_i(clk_sys_i), .spi_miso_i(miso), .spi_miso_oe_i(miso_oe),
    .spi_cs_n_o(cs_n), .spi_sck_o(sck), .spi_mosi_o(mosi));

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Bounded wait: 0 busy, 1 power-down, 2 array fill
  task automatic wait_for(input int sel, input logic val, input int bound);
    logic s;
    for (int n = 0; n <= bound; n++) begin
      @(posedge clk_sys_i);
      #1;
      s = (sel == 0) ? busy : (sel == 1) ? pd : fill;
      if (s === val) return;
    end
    mismatches++;
    $display("BAD wait %0d expected %b seen timeout", sel, val);
    end_of_test();
  endtask

  task automatic pulse(input int which);
    @(posedge clk_sys_i);
    case (which)
      0: we_set <= 1'b1;
      1: op_start <= 1'b1;
      default: op_done <= 1'b1;
    endcase
    @(posedge clk_sys_i);
    we_set   <= 1'b0;
    op_start <= 1'b0;
    op_done  <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
  endtask

  task automatic cmd(input logic [7:0] op, input int nb, input int n_rd);
    spi_host_model_i.frame({op, 32'h0}, nb, n_rd, rd, oe);
  endtask

  task automatic whole(input logic [7:0] op, input int nb, input logic we, input logic go);
    if (we) pulse(0);
    cmd(op, nb, 0);
    check("busy after whole", {15'h0, go}, {15'h0, busy});
    if (go) begin
      cmd(`OP_SUSPEND, 8, 0);
      check("suspend in whole", 16'h0, {15'h0, suspend_status_flag});
      cmd(`OP_READ_STATUS, 8, 8);
      check("status in whole", 16'h0003, rd);
      wait_for(2, 1'b1, W + 50);
      @(posedge clk_sys_i);
      #1;
      check("busy wel after whole", 16'h0, {14'h0, busy, write_enable_latch});
    end
  endtask

  initial begin
    repeat (4) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    #1;
    check("reset flags", 16'h0007, {8'h0, pd, suspend_status_flag, busy, write_enable_latch, miso_oe, e_ok, p_ok, sw_ok});
    $display("test reset done");
    rows[0] = '{{`OP_READ_IDS, 24'h000000, 8'h00}, 32, {MFG, DEV}};
    rows[1] = '{{`OP_READ_IDS, 24'h000001, 8'h00}, 32, {DEV, MFG}};
    rows[2] = '{{`OP_RELEASE_ID, 32'h0}, 32, {DEV, DEV}};
    rows[3] = '{{`OP_READ_STATUS, 32'h0}, 8, 16'h0000};
    foreach (rows[k]) begin
      spi_host_model_i.frame(rows[k].din, rows[k].n_in, 16, rd, oe);
      check("read row", rows[k].exp, rd);
    end
    $display("test reads done");
    whole(`OP_WHOLE_ERASE_A, 8, 1'b0, 1'b0);
    whole(`OP_WHOLE_ERASE_A, 7, 1'b1, 1'b0);
    whole(`OP_WHOLE_ERASE_A, 9, 1'b1, 1'b0);
    bp <= 3'h1;
    whole(`OP_WHOLE_ERASE_B, 8, 1'b1, 1'b0);
    cmp <= 1'b1;
    bp  <= 3'h7;
    whole(`OP_WHOLE_ERASE_B, 8, 1'b1, 1'b1);
    cmp <= 1'b0;
    bp  <= 3'h0;
    whole(`OP_WHOLE_ERASE_A, 8, 1'b1, 1'b1);
    $display("test whole erase done");
    pulse(0);
    pulse(1);
    cmd(`OP_SUSPEND, 8, 0);
    check("erase suspend", 16'h002A, {10'h0, suspend_status_flag, busy, hold, e_ok, p_ok, sw_ok});
    cmd(`OP_WHOLE_ERASE_A, 8, 0);
    check("whole in suspend", 16'h0, {15'h0, busy});
    pulse(1);
    check("erase in suspend", 16'h0, {15'h0, busy});
    cmd(`OP_RESUME, 8, 0);
    check("resume flags", 16'h0, {14'h0, suspend_status_flag, hold});
    wait_for(0, 1'b1, `RESUME_BUSY_CYC);
    cmd(`OP_RESUME, 8, 0);
    check("resume while busy", 16'h0001, {14'h0, suspend_status_flag, busy});
    cmd(`OP_RELEASE_ID, 32, 16);
    check("id while busy", 16'h0, {15'h0, oe});
    pulse(2);
    check("op done", 16'h0, {14'h0, busy, write_enable_latch});
    cmd(`OP_SUSPEND, 8, 0);
    check("suspend idle", 16'h0, {15'h0, suspend_status_flag});
    pulse(0);
    op_prog <= 1'b1;
    pulse(1);
    repeat (`RESUME_BUSY_CYC) @(posedge clk_sys_i);
    cmd(`OP_SUSPEND, 8, 0);
    check("program suspend", 16'h0004, {13'h0, suspend_status_flag, p_ok, sw_ok});
    pulse(1);
    check("program in suspend", 16'h0, {15'h0, busy});
    reset_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    op_prog <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    cmd(`OP_RESUME, 8, 0);
    check("resume after reset", 16'h0, {14'h0, suspend_status_flag, busy});
    $display("test suspend done");
    cmd(`OP_POWER_DOWN, 9, 0);
    repeat (`POWER_DOWN_ENTRY_CYC + 20) @(posedge clk_sys_i);
    check("long power-down frame", 16'h0, {15'h0, pd});
    cmd(`OP_POWER_DOWN, 8, 0);
    wait_for(1, 1'b1, `POWER_DOWN_ENTRY_CYC + 20);
    cmd(`OP_READ_STATUS, 8, 8);
    check("status in power-down", 16'h0, {15'h0, oe});
    cmd(`OP_RELEASE_ID, 8, 0);
    repeat (`FIRST_RELEASE_CYC + 20) @(posedge clk_sys_i);
    cmd(`OP_READ_STATUS, 8, 8);
    check("status after release", 16'h0100, {7'h0, oe, rd[7:0]});
    cmd(`OP_POWER_DOWN, 8, 0);
    wait_for(1, 1'b1, `POWER_DOWN_ENTRY_CYC + 20);
    cmd(`OP_RELEASE_ID, 32, 8);
    check("id release", {8'h0, DEV}, rd);
    repeat (`SECOND_RELEASE_CYC + 20) @(posedge clk_sys_i);
    check("power after id release", 16'h0, {15'h0, pd});
    cmd(`OP_READ_STATUS, 8, 8);
    check("status after id release", 16'h0100, {7'h0, oe, rd[7:0]});
    $display("test power-down done");
    end_of_test();
  end
endmodule
`default_nettype wire
